/* rtl/spcg_gate.sv */
// Sleep-mode peripheral clock gate with APB registers and fault decode
`timescale 1ns/100ps
module spcg_gate (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power mode from the system controller
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    // Peripheral access check: one request bit per gate position
    input wire logic [31:0] unit_access,
    output logic [31:0] unit_fault,
    // Gated unit enables, one per gate position
    output logic [31:0] unit_clk_en,
    // Interrupt
    output logic irq
);
    // Software-visible registers
    logic [31:0] run_gate_reg;
    logic [31:0] run_gate_next;
    logic [31:0] sleep_gate_reg;
    logic [31:0] sleep_gate_next;
    logic [31:0] deep_sleep_gate_reg;
    logic [31:0] deep_sleep_gate_next;
    logic [31:0] run_clock_config_reg;
    logic [31:0] run_clock_config_next;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_status_next;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_mask_next;
    // Datapath and answer flops
    logic [31:0] active_set;
    logic [31:0] en_reg;
    logic [31:0] en_next;
    logic [31:0] fault_reg;
    logic [31:0] fault_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ready_reg;
    logic ready_next;
    logic err_reg;
    logic err_next;
    logic irq_reg;
    logic irq_next;
    // Decode and control
    spcg_pkg::spcg_mode_e mode;
    logic sleep_gating_select;
    logic access_done;
    logic access_end;
    logic wr;
    logic [1:0] irq_clear;
    logic any_fault;
    logic set_changed;

    // Register decode, used both for reads and for writes
    function automatic logic addr_hit(input logic [11:0] a);
        case (a)
            spcg_pkg::RUN_GATE_OFF,
            spcg_pkg::SLEEP_GATE_OFF,
            spcg_pkg::DEEP_GATE_OFF,
            spcg_pkg::CLK_CFG_OFF,
            spcg_pkg::IRQ_STATUS_OFF,
            spcg_pkg::IRQ_MASK_OFF,
            spcg_pkg::MODE_STATUS_OFF: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    // Positions that clock a real unit; all others are reserved and never enabled
    function automatic logic unit_at(input int n);
        case (n)
            spcg_pkg::COMP_B_BIT: unit_at = 1'b1;
            spcg_pkg::COMP_A_BIT: unit_at = 1'b1;
            spcg_pkg::COUNTER_D_BIT: unit_at = 1'b1;
            spcg_pkg::COUNTER_A_BIT + 2: unit_at = 1'b1;
            spcg_pkg::COUNTER_A_BIT + 1: unit_at = 1'b1;
            spcg_pkg::COUNTER_A_BIT: unit_at = 1'b1;
            spcg_pkg::TWO_WIRE_B_BIT: unit_at = 1'b1;
            spcg_pkg::TWO_WIRE_A_BIT: unit_at = 1'b1;
            spcg_pkg::SYNC_B_BIT: unit_at = 1'b1;
            spcg_pkg::SYNC_A_BIT: unit_at = 1'b1;
            spcg_pkg::ASYNC_B_BIT: unit_at = 1'b1;
            spcg_pkg::ASYNC_A_BIT: unit_at = 1'b1;
            default: unit_at = 1'b0;
        endcase
    endfunction

    // Select bit chooses whether sleep states use their own gating sets
    assign sleep_gating_select = run_clock_config_reg[spcg_pkg::SLEEP_SEL_BIT];
    // Answer on the access cycle after setup; one wait state holds prdata stable
    assign access_done = psel && penable && !ready_reg;
    // Writes land on the edge where the master sees pready, never earlier, so a
    // read of the same register in the next transfer already shows the new value
    assign access_end = psel && penable && ready_reg;
    assign wr = access_end && pwrite && addr_hit(paddr);
    // Write-one-to-clear pattern for the event status
    assign irq_clear = (wr && (paddr == spcg_pkg::IRQ_STATUS_OFF)) ? pwdata[1:0] : 2'h0;

    // Pick the mode; deep sleep outranks sleep
    always_comb begin
        if (deep_sleep_req) begin
            mode = spcg_pkg::SPCG_DEEP;
        end else if (sleep_req) begin
            mode = spcg_pkg::SPCG_SLEEP;
        end else begin
            mode = spcg_pkg::SPCG_RUN;
        end
    end

    // Choose the gating set in force; sleep sets need the select bit
    // With the select clear, both sleep depths fall back to the run set
    always_comb begin
        case (mode)
            spcg_pkg::SPCG_SLEEP: begin
                active_set = sleep_gating_select ? sleep_gate_reg : run_gate_reg;
            end
            spcg_pkg::SPCG_DEEP: begin
                active_set = sleep_gating_select ? deep_sleep_gate_reg : run_gate_reg;
            end
            default: begin
                active_set = run_gate_reg;
            end
        endcase
    end

    // Gating registers; write mask keeps reserved bits zero
    always_comb begin
        run_gate_next = run_gate_reg;
        sleep_gate_next = sleep_gate_reg;
        deep_sleep_gate_next = deep_sleep_gate_reg;
        run_clock_config_next = run_clock_config_reg;
        irq_mask_next = irq_mask_reg;
        if (wr) begin
            case (paddr)
                spcg_pkg::RUN_GATE_OFF: begin
                    run_gate_next = pwdata & spcg_pkg::GATE_WMASK;
                end
                spcg_pkg::SLEEP_GATE_OFF: begin
                    sleep_gate_next = pwdata & spcg_pkg::GATE_WMASK;
                end
                spcg_pkg::DEEP_GATE_OFF: begin
                    deep_sleep_gate_next = pwdata & spcg_pkg::GATE_WMASK;
                end
                spcg_pkg::CLK_CFG_OFF: begin
                    run_clock_config_next = pwdata & spcg_pkg::CLK_CFG_WMASK;
                end
                spcg_pkg::IRQ_MASK_OFF: begin
                    irq_mask_next = pwdata[1:0];
                end
                default: begin
                    // Status and readback words take no plain write here
                end
            endcase
        end
    end

    // Register file
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_gate_reg <= spcg_pkg::GATE_RESET;
            sleep_gate_reg <= spcg_pkg::GATE_RESET;
            deep_sleep_gate_reg <= spcg_pkg::GATE_RESET;
            run_clock_config_reg <= spcg_pkg::CLK_CFG_RESET;
            irq_mask_reg <= spcg_pkg::IRQ_RESET;
        end else begin
            run_gate_reg <= run_gate_next;
            sleep_gate_reg <= sleep_gate_next;
            deep_sleep_gate_reg <= deep_sleep_gate_next;
            run_clock_config_reg <= run_clock_config_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    // Enable and fault per unit position; reserved positions keep their enable low
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : gen_unit
            assign en_next[g] = active_set[g] && unit_at(g);
            assign fault_next[g] = unit_access[g] && !en_reg[g];
        end
    endgenerate
    // Event sources: a faulted access, or any change of the enables in force
    assign any_fault = |fault_next;
    assign set_changed = (en_next != en_reg);

    // Sticky events; a new event wins over a write-one clear
    always_comb begin
        irq_status_next = irq_status_reg & ~irq_clear;
        if (any_fault) begin
            irq_status_next[spcg_pkg::EV_FAULT_BIT] = 1'b1;
        end
        if (set_changed) begin
            irq_status_next[spcg_pkg::EV_SWITCH_BIT] = 1'b1;
        end
        // Mask is taken in its next value so irq follows a mask write at once
        irq_next = |(irq_status_next & irq_mask_next);
    end

    // APB read data and answer
    always_comb begin
        rdata_next = 32'h00000000;
        ready_next = access_done;
        err_next = access_done && !addr_hit(paddr);
        if (access_done && !pwrite) begin
            // Reserved bits and unmapped words read as zero
            case (paddr)
                spcg_pkg::RUN_GATE_OFF: begin
                    rdata_next = run_gate_reg;
                end
                spcg_pkg::SLEEP_GATE_OFF: begin
                    rdata_next = sleep_gate_reg;
                end
                spcg_pkg::DEEP_GATE_OFF: begin
                    rdata_next = deep_sleep_gate_reg;
                end
                spcg_pkg::CLK_CFG_OFF: begin
                    rdata_next = run_clock_config_reg;
                end
                spcg_pkg::IRQ_STATUS_OFF: begin
                    rdata_next = {30'h00000000, irq_status_reg};
                end
                spcg_pkg::IRQ_MASK_OFF: begin
                    rdata_next = {30'h00000000, irq_mask_reg};
                end
                spcg_pkg::MODE_STATUS_OFF: begin
                    rdata_next = en_reg;
                end
                default: begin
                    rdata_next = 32'h00000000;
                end
            endcase
        end
    end

    // Unit enable and fault flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_reg <= spcg_pkg::GATE_RESET;
            fault_reg <= 32'h00000000;
        end else begin
            en_reg <= en_next;
            fault_reg <= fault_next;
        end
    end

    // Event and interrupt flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_status_reg <= spcg_pkg::IRQ_RESET;
            irq_reg <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_reg <= irq_next;
        end
    end

    // Bus answer flops; the answer is a one-cycle pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= 32'h00000000;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            err_reg <= err_next;
        end
    end

    // Enables change at the rising edge only; the gating cell latches them
    // while the clock is low, so a unit clock never gets a runt pulse
    // Every output below comes straight from a flop
    assign unit_clk_en = en_reg;
    assign unit_fault = fault_reg;
    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign irq = irq_reg;
endmodule

/* rtl/spcg_pkg.sv */
// Package of offsets, field positions and reset values for the sleep clock gate
package spcg_pkg;
    // Register byte offsets
    localparam logic [11:0] RUN_GATE_OFF = 12'h104;
    localparam logic [11:0] SLEEP_GATE_OFF = 12'h114;
    localparam logic [11:0] DEEP_GATE_OFF = 12'h124;
    localparam logic [11:0] CLK_CFG_OFF = 12'h060;
    localparam logic [11:0] IRQ_STATUS_OFF = 12'h200;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h204;
    localparam logic [11:0] MODE_STATUS_OFF = 12'h208;
    // Gate bit positions
    localparam int ASYNC_A_BIT = 0;
    localparam int ASYNC_B_BIT = 1;
    localparam int SYNC_A_BIT = 4;
    localparam int SYNC_B_BIT = 5;
    localparam int TWO_WIRE_A_BIT = 12;
    localparam int TWO_WIRE_B_BIT = 14;
    localparam int COUNTER_A_BIT = 16;
    localparam int COUNTER_D_BIT = 19;
    localparam int COMP_A_BIT = 24;
    localparam int COMP_B_BIT = 25;
    // Writable bits of a gating register, reserved bits read zero
    localparam logic [31:0] GATE_WMASK = 32'h030F5033;
    localparam logic [31:0] GATE_RESET = 32'h00000000;
    // Sleep-gating select bit in the clock configuration register
    localparam int SLEEP_SEL_BIT = 27;
    localparam logic [31:0] CLK_CFG_WMASK = 32'h08000000;
    localparam logic [31:0] CLK_CFG_RESET = 32'h00000000;
    // Interrupt events: bit 0 fault on gated unit, bit 1 gating set changed
    localparam int EV_FAULT_BIT = 0;
    localparam int EV_SWITCH_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // Power modes
    typedef enum logic [1:0] {
        SPCG_RUN,
        SPCG_SLEEP,
        SPCG_DEEP
    } spcg_mode_e;
endpackage

/* testbench/spcg_gate_checker.sv */
// Port assertions for the sleep clock gate
`timescale 1ns/100ps
module spcg_gate_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Mode, units and interrupt
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic [31:0] unit_access,
    input wire logic [31:0] unit_fault,
    input wire logic [31:0] unit_clk_en,
    input wire logic irq
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_acc; psel && penable && !pready |=> pready; endproperty
    a_acc: assert property (p_acc) else $error("access phase not answered");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_idle; !psel |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("ready without select");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    // Enables steady for two cycles, so either source of the check agrees
    property p_fault;
        $stable(unit_clk_en) ##1 $stable(unit_clk_en)
            |-> unit_fault == $past(unit_access & ~unit_clk_en);
    endproperty
    a_fault: assert property (p_fault) else $error("fault mismatch");
    property p_res; (unit_clk_en & ~spcg_pkg::GATE_WMASK) == 32'h00000000; endproperty
    a_res: assert property (p_res) else $error("reserved enable set");
    property p_rst; $fell(reset) |-> unit_clk_en == 32'h00000000 && !irq; endproperty
    a_rst: assert property (p_rst) else $error("enable after reset");
    property p_hold;
        (!psel && $stable(sleep_req) && $stable(deep_sleep_req))[*3] |=> $stable(unit_clk_en);
    endproperty
    a_hold: assert property (p_hold) else $error("enable moved");
    c_err: cover property (pready && pslverr);
    c_fault: cover property (unit_fault != 32'h00000000);
    c_irq: cover property (irq);
endmodule
bind spcg_gate spcg_gate_checker spcg_gate_checker_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .unit_access(unit_access), .unit_fault(unit_fault),
    .unit_clk_en(unit_clk_en), .irq(irq));

/* testbench/spcg_gate_bench.sv */
// Self-checking bench for the sleep clock gate
`timescale 1ns/100ps
module spcg_gate_bench;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, sleep_req, deep_sleep_req, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, unit_access, unit_fault, unit_clk_en, rdat, bit_v;
    int num_errors = 0;
    int check_count = 0;
    spcg_gate spcg_gate_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .unit_access(unit_access), .unit_fault(unit_fault), .unit_clk_en(unit_clk_en), .irq(irq));
    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // APB transfer; the watchdog bounds the wait for ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Enables follow the active set one cycle late
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    task automatic stop_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog, far beyond the expected run of about 290 cycles
    initial begin
        #50000;
        num_errors++;
        stop_test();
    end
    // Main sequence
    initial begin
        {reset, psel, penable, pwrite, sleep_req, deep_sleep_req} = 6'h20;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        unit_access = 32'h00000000;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        chk(unit_clk_en, 32'h00000000);
        apb(1'b0, spcg_pkg::SLEEP_GATE_OFF, 32'h00000000);
        chk(rdat, 32'h00000000);
        apb(1'b1, spcg_pkg::SLEEP_GATE_OFF, 32'hFFFFFFFF);
        apb(1'b0, spcg_pkg::SLEEP_GATE_OFF, 32'h00000000);
        chk(rdat, 32'h030F5033);
        apb(1'b1, spcg_pkg::RUN_GATE_OFF, 32'h00000011);
        apb(1'b1, spcg_pkg::DEEP_GATE_OFF, 32'h02000000);
        sleep_req <= 1'b1;
        settle();
        chk(unit_clk_en, 32'h00000011);
        apb(1'b1, spcg_pkg::CLK_CFG_OFF, 32'h08000000);
        settle();
        chk(unit_clk_en, 32'h030F5033);
        deep_sleep_req <= 1'b1;
        settle();
        chk(unit_clk_en, 32'h02000000);
        deep_sleep_req <= 1'b0;
        unit_access <= 32'h030F5033;
        // Walk one enable over every position, reserved ones too
        for (int i = 0; i < 32; i++) begin
            bit_v = 32'h00000001 << i;
            apb(1'b1, spcg_pkg::SLEEP_GATE_OFF, bit_v);
            settle();
            chk(unit_clk_en, 32'h030F5033 & bit_v);
            chk(unit_fault, 32'h030F5033 & ~bit_v);
        end
        unit_access <= 32'h00000000;
        apb(1'b1, spcg_pkg::IRQ_MASK_OFF, 32'h00000001);
        apb(1'b0, spcg_pkg::IRQ_STATUS_OFF, 32'h00000000);
        chk({rdat[30:0], irq}, 32'h00000007);
        apb(1'b1, spcg_pkg::IRQ_STATUS_OFF, 32'h00000003);
        apb(1'b0, spcg_pkg::IRQ_STATUS_OFF, 32'h00000000);
        chk({rdat[30:0], irq}, 32'h00000000);
        apb(1'b0, 12'h300, 32'h00000000);
        chk({rdat[30:0], rerr}, 32'h00000001);
        sleep_req <= 1'b0;
        settle();
        chk(unit_clk_en, 32'h00000011);
        apb(1'b0, spcg_pkg::MODE_STATUS_OFF, 32'h00000000);
        chk(rdat, 32'h00000011);
        stop_test();
    end
endmodule
